// File: shared/pes_pkg.sv
// shared constants and carrier types for the error severity and status register pair
package pes_pkg;

  localparam int          PES_DATA_W         = 32;
  localparam int          PES_ADDR_W         = 12;
  localparam int          PES_BE_W           = PES_DATA_W / 8;

  // configuration space offsets
  localparam logic [11:0] PES_ADDR_SEVERITY  = 12'h10C;
  localparam logic [11:0] PES_ADDR_CORR_STAT = 12'h110;

  // uncorrectable severity register layout
  localparam logic [31:0] PES_SEV_RESET      = 32'h0003_2030;
  localparam logic [31:0] PES_SEV_RW_MASK    = 32'h001F_F030;
  localparam int          PES_SEV_UR         = 20;
  localparam int          PES_SEV_ECRC       = 19;
  localparam int          PES_SEV_MALFORMED  = 18;
  localparam int          PES_SEV_RX_OVFL    = 17;
  localparam int          PES_SEV_UNXP_CPL   = 16;
  localparam int          PES_SEV_CPL_ABORT  = 15;
  localparam int          PES_SEV_CPL_TMO    = 14;
  localparam int          PES_SEV_FLOW_CTRL  = 13;
  localparam int          PES_SEV_POISONED   = 12;
  localparam int          PES_SEV_SURPRISE   = 5;
  localparam int          PES_SEV_LINK_PROTO = 4;

  // correctable status register layout
  localparam logic [31:0] PES_COR_RESET      = 32'h0000_0000;
  localparam logic [31:0] PES_COR_IMPL_MASK  = 32'h0000_31C1;
  localparam int          PES_COR_RX_ERR     = 0;
  localparam int          PES_COR_SYM_TLP    = 6;
  localparam int          PES_COR_SYM_DLLP   = 7;
  localparam int          PES_COR_REPLAY_ROL = 8;
  localparam int          PES_COR_REPLAY_TMO = 12;
  localparam int          PES_COR_ADVISORY   = 13;

  localparam logic [31:0] PES_ZERO_WORD      = 32'h0000_0000;

  // one configuration access, write and read strobes are single-cycle
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [PES_ADDR_W-1:0] addr;
    logic [PES_BE_W-1:0]   be;
    logic [PES_DATA_W-1:0] wdata;
  } pes_cfg_req_t;

  // correctable event sources from link and physical layers, one-cycle pulses
  typedef struct packed {
    logic symbol_error;
    logic rx_dllp;
    logic rx_tlp;
    logic replay_timeout;
    logic replay_rollover;
    logic advisory_nonfatal;
  } pes_corr_evt_t;

endpackage

// File: hdl/pes_w1c_bits.sv
// sticky status bits, set by hardware and cleared by a write of one
module pes_w1c_bits
  import pes_pkg::*;
#(
  parameter int                 WIDTH     = 32,
  parameter logic [WIDTH-1:0]   IMPL_MASK = '1,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] set_in,
  input  wire logic [WIDTH-1:0] clr_in,
  output wire logic [WIDTH-1:0] status_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pes_w1c_bits: WIDTH must be at least one");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    if (IMPL_MASK[i]) begin : g_impl
      // one flop per bit keeps each output bit to a single driver
      logic bit_reg;
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          bit_reg <= RESET_VAL[i];
        end else if (set_in[i]) begin
          // a detection in the clearing cycle wins
          bit_reg <= 1'b1;
        end else if (clr_in[i]) begin
          bit_reg <= 1'b0;
        end
      end
      assign status_out[i] = bit_reg;
    end else begin : g_rsvd
      assign status_out[i] = 1'b0;
    end
  end

endmodule

// File: hdl/pes_regs.sv
// uncorrectable severity and correctable status registers with error message routing

module pes_regs
  import pes_pkg::*;
#(
  parameter int                   DATA_W = PES_DATA_W,
  parameter int                   ADDR_W = PES_ADDR_W
) (
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  input  wire pes_cfg_req_t       cfg_req_in,
  input  wire logic [DATA_W-1:0]  uerr_evt_in,
  input  wire logic [DATA_W-1:0]  uerr_mask_in,
  input  wire pes_corr_evt_t      corr_evt_in,
  output logic      [DATA_W-1:0]  cfg_rdata_out,
  output logic                    cfg_rvalid_out,
  output logic                    fatal_msg_out,
  output logic                    nonfatal_msg_out,
  output logic      [DATA_W-1:0]  severity_out,
  output logic      [DATA_W-1:0]  corr_status_out
);

  if (DATA_W != PES_DATA_W || ADDR_W != PES_ADDR_W || DATA_W % 8 != 0) begin : g_bad_param
    $error("pes_regs: register layout needs 32-bit data and 12-bit offsets");
  end

  localparam int BE_W = DATA_W / 8;

  logic [DATA_W-1:0] sev_reg;
  logic [DATA_W-1:0] sev_next;
  logic [DATA_W-1:0] byte_mask;
  logic              hit_sev;
  logic              hit_cor;
  logic [DATA_W-1:0] cor_set;
  logic [DATA_W-1:0] cor_clr;
  logic [DATA_W-1:0] cor_status;
  logic [DATA_W-1:0] uerr_live;
  logic              fatal_next;
  logic              nonfatal_next;
  logic [DATA_W-1:0] rdata_next;

  // byte enables widen into a bit mask so partial writes touch only their lanes
  for (genvar b = 0; b < BE_W; b++) begin : g_lane
    assign byte_mask[b*8 +: 8] = {8{cfg_req_in.be[b]}};
  end

  assign hit_sev = (cfg_req_in.addr == PES_ADDR_SEVERITY);
  assign hit_cor = (cfg_req_in.addr == PES_ADDR_CORR_STAT);

  // severity register: only the implemented selectors are writable
  always_comb begin
    sev_next = sev_reg;
    if (cfg_req_in.wr && hit_sev) begin
      sev_next = (sev_reg & ~(byte_mask & PES_SEV_RW_MASK))
               | (cfg_req_in.wdata & byte_mask & PES_SEV_RW_MASK);
    end
    // reserved ranges and the undefined bit 0 are forced low
    sev_next = sev_next & PES_SEV_RW_MASK;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sev_reg <= PES_SEV_RESET;
    end else begin
      sev_reg <= sev_next;
    end
  end

  // correctable event decode; a TLP or DLLP symbol error also counts as a receiver error
  always_comb begin
    cor_set                     = PES_ZERO_WORD;
    cor_set[PES_COR_RX_ERR]     = corr_evt_in.symbol_error;
    cor_set[PES_COR_SYM_TLP]    = corr_evt_in.symbol_error && corr_evt_in.rx_tlp;
    cor_set[PES_COR_SYM_DLLP]   = corr_evt_in.symbol_error && corr_evt_in.rx_dllp;
    cor_set[PES_COR_REPLAY_ROL] = corr_evt_in.replay_rollover;
    cor_set[PES_COR_REPLAY_TMO] = corr_evt_in.replay_timeout;
    cor_set[PES_COR_ADVISORY]   = corr_evt_in.advisory_nonfatal;
  end

  // only ones written clear; zeros leave the bit alone
  assign cor_clr = (cfg_req_in.wr && hit_cor) ? (cfg_req_in.wdata & byte_mask)
                                              : PES_ZERO_WORD;

  pes_w1c_bits #(
    .WIDTH     (DATA_W),
    .IMPL_MASK (PES_COR_IMPL_MASK),
    .RESET_VAL (PES_COR_RESET)
  ) u_cor_status (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .set_in     (cor_set),
    .clr_in     (cor_clr),
    .status_out (cor_status)
  );

  // masked errors still reach their status bit elsewhere but never a message
  assign uerr_live = uerr_evt_in & ~uerr_mask_in & PES_SEV_RW_MASK;

  // the severity in force at detection picks the message class
  assign fatal_next    = |(uerr_live & sev_reg);
  assign nonfatal_next = |(uerr_live & ~sev_reg);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fatal_msg_out    <= 1'b0;
      nonfatal_msg_out <= 1'b0;
    end else begin
      fatal_msg_out    <= fatal_next;
      nonfatal_msg_out <= nonfatal_next;
    end
  end

  // read returns the value before any same-cycle write; unmapped offsets read zero
  always_comb begin
    rdata_next = PES_ZERO_WORD;
    if (hit_sev) begin
      rdata_next = sev_reg;
    end else if (hit_cor) begin
      rdata_next = cor_status;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_rdata_out  <= PES_ZERO_WORD;
      cfg_rvalid_out <= 1'b0;
    end else begin
      cfg_rvalid_out <= cfg_req_in.rd;
      if (cfg_req_in.rd) begin
        cfg_rdata_out <= rdata_next;
      end
    end
  end

  assign severity_out    = sev_reg;
  assign corr_status_out = cor_status;

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_sev_rsvd_zero:
    assert property ((sev_reg & ~PES_SEV_RW_MASK) == PES_ZERO_WORD)
    else $error("reserved severity bits not zero");

  a_sev_full_write:
    assert property (cfg_req_in.wr && hit_sev && (&cfg_req_in.be)
                     |=> sev_reg == ($past(cfg_req_in.wdata) & PES_SEV_RW_MASK))
    else $error("severity write not taken");

  a_sev_holds_idle:
    assert property (!(cfg_req_in.wr && hit_sev) |=> $stable(sev_reg))
    else $error("severity changed without a write");

  a_sev_read_bit0:
    assert property (cfg_req_in.rd && hit_sev |=> cfg_rvalid_out && !cfg_rdata_out[0]
                     && cfg_rdata_out == $past(sev_reg))
    else $error("severity read value wrong");

  a_fatal_route:
    assert property ((|(uerr_evt_in & ~uerr_mask_in & sev_reg)) |=> fatal_msg_out)
    else $error("fatal error without fatal message");

  a_nonfatal_route:
    assert property ((|(uerr_evt_in & ~uerr_mask_in & PES_SEV_RW_MASK & ~sev_reg))
                     |=> nonfatal_msg_out)
    else $error("nonfatal error without nonfatal message");

  a_masked_silent:
    assert property ((uerr_evt_in & ~uerr_mask_in) == PES_ZERO_WORD
                     |=> !fatal_msg_out && !nonfatal_msg_out)
    else $error("message sent for masked error");

  a_cor_rsvd_zero:
    assert property ((cor_status & ~PES_COR_IMPL_MASK) == PES_ZERO_WORD)
    else $error("reserved status bits not zero");

  a_cor_w1c_only:
    assert property (cor_set == PES_ZERO_WORD
                     |=> cor_status == ($past(cor_status) & ~$past(cor_clr)))
    else $error("status cleared without written one");

  a_cor_set_wins:
    assert property (corr_evt_in.symbol_error && cor_clr[PES_COR_RX_ERR]
                     |=> cor_status[PES_COR_RX_ERR] ##1 cor_status[PES_COR_RX_ERR]
                         || $past(cor_clr[PES_COR_RX_ERR]))
    else $error("detection lost to same-cycle clear");

  a_tlp_symbol_err:
    assert property (corr_evt_in.symbol_error && corr_evt_in.rx_tlp
                     |=> cor_status[PES_COR_SYM_TLP] && cor_status[PES_COR_RX_ERR])
    else $error("bad transaction packet not flagged");

  a_dllp_symbol_err:
    assert property (corr_evt_in.symbol_error && corr_evt_in.rx_dllp
                     |=> cor_status[PES_COR_SYM_DLLP] && cor_status[PES_COR_RX_ERR])
    else $error("bad link packet not flagged");

  a_rx_err_any:
    assert property (corr_evt_in.symbol_error |=> cor_status[PES_COR_RX_ERR])
    else $error("receiver error not flagged");

  a_replay_timeout:
    assert property (corr_evt_in.replay_timeout |=> cor_status[PES_COR_REPLAY_TMO])
    else $error("replay timeout not flagged");

  a_replay_rollover:
    assert property (corr_evt_in.replay_rollover |=> cor_status[PES_COR_REPLAY_ROL])
    else $error("replay rollover not flagged");

  a_advisory_sticky:
    assert property (cor_status[PES_COR_ADVISORY] && !cor_clr[PES_COR_ADVISORY]
                     |=> cor_status[PES_COR_ADVISORY])
    else $error("advisory flag lost without clear");

  // field, byte lane, routing and read path checks, each on one selector, the packet error selectors 18 to 12, one flag or a whole register

  a_ur_sev_write:
    assert property (cfg_req_in.wr && hit_sev && cfg_req_in.be[PES_SEV_UR / 8]
                     |=> sev_reg[PES_SEV_UR] == $past(cfg_req_in.wdata[PES_SEV_UR]))
    else $error("unsupported request severity write lost");

  a_ecrc_sev_write:
    assert property (cfg_req_in.wr && hit_sev && cfg_req_in.be[PES_SEV_ECRC / 8]
                     |=> sev_reg[PES_SEV_ECRC] == $past(cfg_req_in.wdata[PES_SEV_ECRC]))
    else $error("end-to-end CRC severity write lost");

  a_pkt_sev_write:
    assert property (cfg_req_in.wr && hit_sev && cfg_req_in.be[PES_SEV_MALFORMED / 8]
                     && cfg_req_in.be[PES_SEV_POISONED / 8]
                     |=> sev_reg[PES_SEV_MALFORMED:PES_SEV_POISONED]
                         == $past(cfg_req_in.wdata[PES_SEV_MALFORMED:PES_SEV_POISONED]))
    else $error("packet error severity write lost");

  a_surprise_sev_write:
    assert property (cfg_req_in.wr && hit_sev && cfg_req_in.be[PES_SEV_SURPRISE / 8]
                     |=> sev_reg[PES_SEV_SURPRISE] == $past(cfg_req_in.wdata[PES_SEV_SURPRISE]))
    else $error("surprise down severity write lost");

  a_link_sev_write:
    assert property (cfg_req_in.wr && hit_sev && cfg_req_in.be[PES_SEV_LINK_PROTO / 8]
                     |=> sev_reg[PES_SEV_LINK_PROTO]
                         == $past(cfg_req_in.wdata[PES_SEV_LINK_PROTO]))
    else $error("link protocol severity write lost");

  a_sev_lane_keep:
    assert property (cfg_req_in.wr && hit_sev
                     |=> ((sev_reg ^ $past(sev_reg)) & ~$past(byte_mask)) == PES_ZERO_WORD)
    else $error("severity changed in a disabled byte lane");

  a_cor_lane_keep:
    assert property (cfg_req_in.wr && hit_cor
                     |=> ($past(cor_status) & ~cor_status & ~$past(byte_mask)) == PES_ZERO_WORD)
    else $error("status cleared in a disabled byte lane");

  a_ur_route:
    assert property (uerr_evt_in[PES_SEV_UR] && !uerr_mask_in[PES_SEV_UR]
                     |=> ($past(sev_reg[PES_SEV_UR]) ? fatal_msg_out : nonfatal_msg_out))
    else $error("unsupported request sent with wrong message");

  a_ecrc_route:
    assert property (uerr_evt_in[PES_SEV_ECRC] && !uerr_mask_in[PES_SEV_ECRC]
                     |=> ($past(sev_reg[PES_SEV_ECRC]) ? fatal_msg_out : nonfatal_msg_out))
    else $error("end-to-end CRC error sent with wrong message");

  a_surprise_route:
    assert property (uerr_evt_in[PES_SEV_SURPRISE] && !uerr_mask_in[PES_SEV_SURPRISE]
                     |=> ($past(sev_reg[PES_SEV_SURPRISE]) ? fatal_msg_out : nonfatal_msg_out))
    else $error("surprise down sent with wrong message");

  a_link_route:
    assert property (uerr_evt_in[PES_SEV_LINK_PROTO] && !uerr_mask_in[PES_SEV_LINK_PROTO]
                     |=> ($past(sev_reg[PES_SEV_LINK_PROTO]) ? fatal_msg_out : nonfatal_msg_out))
    else $error("link protocol error sent with wrong message");

  a_fatal_quiet:
    assert property ((uerr_evt_in & ~uerr_mask_in & sev_reg) == PES_ZERO_WORD
                     |=> !fatal_msg_out)
    else $error("fatal message without fatal error");

  a_nonfatal_quiet:
    assert property ((uerr_evt_in & ~uerr_mask_in & PES_SEV_RW_MASK & ~sev_reg) == PES_ZERO_WORD
                     |=> !nonfatal_msg_out)
    else $error("nonfatal message without nonfatal error");

  a_cor_read_value:
    assert property (cfg_req_in.rd && hit_cor
                     |=> cfg_rvalid_out && cfg_rdata_out == $past(cor_status))
    else $error("status read value wrong");

  a_cor_rsvd_read:
    assert property (cfg_req_in.rd && hit_cor
                     |=> (cfg_rdata_out & ~PES_COR_IMPL_MASK) == PES_ZERO_WORD)
    else $error("reserved status bits read non-zero");

  a_sev_rsvd_read:
    assert property (cfg_req_in.rd && hit_sev
                     |=> (cfg_rdata_out & ~PES_SEV_RW_MASK) == PES_ZERO_WORD)
    else $error("reserved severity bits read non-zero");

  a_unmapped_read:
    assert property (cfg_req_in.rd && !hit_sev && !hit_cor
                     |=> cfg_rvalid_out && cfg_rdata_out == PES_ZERO_WORD)
    else $error("unmapped offset read non-zero");

  a_rvalid_idle:
    assert property (!cfg_req_in.rd |=> !cfg_rvalid_out)
    else $error("read answer without read");

  a_rdata_holds:
    assert property (!cfg_req_in.rd |=> $stable(cfg_rdata_out))
    else $error("read data changed without read");

  a_rx_err_cause:
    assert property (!corr_evt_in.symbol_error |=> !$rose(cor_status[PES_COR_RX_ERR]))
    else $error("receiver error set without symbol error");

  a_tlp_err_cause:
    assert property (!(corr_evt_in.symbol_error && corr_evt_in.rx_tlp)
                     |=> !$rose(cor_status[PES_COR_SYM_TLP]))
    else $error("transaction packet flag set without cause");

  a_dllp_err_cause:
    assert property (!(corr_evt_in.symbol_error && corr_evt_in.rx_dllp)
                     |=> !$rose(cor_status[PES_COR_SYM_DLLP]))
    else $error("link packet flag set without cause");

  a_replay_tmo_cause:
    assert property (!corr_evt_in.replay_timeout |=> !$rose(cor_status[PES_COR_REPLAY_TMO]))
    else $error("replay timeout flag set without cause");

  a_replay_rol_cause:
    assert property (!corr_evt_in.replay_rollover |=> !$rose(cor_status[PES_COR_REPLAY_ROL]))
    else $error("replay rollover flag set without cause");

  a_advisory_cause:
    assert property (!corr_evt_in.advisory_nonfatal |=> !$rose(cor_status[PES_COR_ADVISORY]))
    else $error("advisory flag set without cause");

endmodule

// File: dv/pes_regs_tb_top.sv
// self-checking testbench for the error severity and correctable status register pair
`define CHK(act, exp) begin cmp_count++; if ((act) !== (exp)) begin error_cnt++; $display("MISMATCH t=%0t got %h expected %h", $time, (act), (exp)); end end
module pes_regs_tb_top import pes_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] SEV = PES_ADDR_SEVERITY;
  localparam logic [11:0] COR = PES_ADDR_CORR_STAT;
  logic          clk_in;
  logic          rst_in;
  pes_cfg_req_t  req;
  logic [31:0]   uevt;
  logic [31:0]   umask;
  pes_corr_evt_t cevt;
  logic [31:0]   rdata;
  logic          rvalid;
  logic          fatal;
  logic          nonfatal;
  logic [31:0]   sev_o;
  logic [31:0]   cor_o;
  int            error_cnt = 0;
  int            cmp_count = 0;
  int            cycles    = 0;

  pes_regs dut (
    .clk_in           (clk_in),
    .rst_in           (rst_in),
    .cfg_req_in       (req),
    .uerr_evt_in      (uevt),
    .uerr_mask_in     (umask),
    .corr_evt_in      (cevt),
    .cfg_rdata_out    (rdata),
    .cfg_rvalid_out   (rvalid),
    .fatal_msg_out    (fatal),
    .nonfatal_msg_out (nonfatal),
    .severity_out     (sev_o),
    .corr_status_out  (cor_o)
  );

  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // every task starts and ends just after a falling edge; the idle cycle in front of
  // each request keeps a strobe from being lowered and raised in one time step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(negedge clk_in);
    req.wr = 1'b1;
    req.addr = a;
    req.be = be;
    req.wdata = d;
    @(negedge clk_in);
    req.wr = 1'b0;
  endtask

  // bit 0 of severity is undefined but reads zero here; callers still pass a mask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(negedge clk_in);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_in);
    req.rd = 1'b0;
    `CHK(rvalid, 1'b1)
    `CHK(rdata & m, e)
  endtask

  task automatic upulse(input logic [31:0] v, input logic f, input logic n);
    uevt = v;
    @(negedge clk_in);
    uevt = '0;
    `CHK({fatal, nonfatal}, {f, n})
    @(negedge clk_in);
    `CHK({fatal, nonfatal}, 2'h0)
  endtask

  task automatic t_reset();
    `CHK(sev_o & 32'hFFFF_FFFE, PES_SEV_RESET)
    rd_chk(SEV, 32'hFFFF_FFFE, PES_SEV_RESET);
    rd_chk(COR, 32'hFFFF_FFFF, PES_COR_RESET);
  endtask

  task automatic t_sev_rw();
    wr(SEV, 32'hFFFF_FFFF, 4'hF);
    rd_chk(SEV, 32'hFFFF_FFFE, 32'h001F_F030);
    wr(SEV, PES_ZERO_WORD, 4'hF);
    rd_chk(SEV, 32'hFFFF_FFFE, 32'h0000_0000);
    wr(SEV, 32'hFFFF_FFFF, 4'h4);
    rd_chk(SEV, 32'hFFFF_FFFE, 32'h001F_0000);
    wr(12'h114, 32'hFFFF_FFFF, 4'hF);
    rd_chk(SEV, 32'hFFFF_FFFE, 32'h001F_0000);
    rd_chk(12'h114, 32'hFFFF_FFFF, 32'h0000_0000);
  endtask

  task automatic t_msg();
    for (int b = 0; b < 32; b++) begin
      if (PES_SEV_RW_MASK[b]) begin
        wr(SEV, 32'h1 << b, 4'hF);
        upulse(32'h1 << b, 1'b1, 1'b0);
        wr(SEV, PES_ZERO_WORD, 4'hF);
        upulse(32'h1 << b, 1'b0, 1'b1);
        umask = 32'h1 << b;
        upulse(32'h1 << b, 1'b0, 1'b0);
        umask = '0;
      end
    end
    upulse(32'h0000_0002, 1'b0, 1'b0);
    wr(SEV, 32'h0004_0000, 4'hF);
    upulse(32'h0004_0010, 1'b1, 1'b1);
  endtask

  task automatic t_corr();
    logic [5:0]  ev [7] = '{6'h20, 6'h28, 6'h30, 6'h04, 6'h02, 6'h01, 6'h08};
    logic [31:0] ex [7] = '{32'h1, 32'h41, 32'h81, 32'h1000, 32'h100, 32'h2000, 32'h0};
    for (int i = 0; i < 7; i++) begin
      wr(COR, 32'hFFFF_FFFF, 4'hF);
      cevt = ev[i];
      @(negedge clk_in);
      cevt = '0;
      `CHK(cor_o, ex[i])
      rd_chk(COR, 32'hFFFF_FFFF, ex[i]);
    end
  endtask

  task automatic t_w1c();
    cevt = 6'h3F;
    @(negedge clk_in);
    cevt = '0;
    `CHK(cor_o, 32'h0000_31C1)
    wr(COR, PES_ZERO_WORD, 4'hF);
    `CHK(cor_o, 32'h0000_31C1)
    wr(COR, 32'hFFFF_FFFF, 4'h2);
    `CHK(cor_o, 32'h0000_00C1)
    wr(COR, 32'h0000_0040, 4'hF);
    `CHK(cor_o, 32'h0000_0081)
    // detection and clear of bit 0 in the same cycle
    cevt = 6'h20;
    wr(COR, 32'h0000_0001, 4'hF);
    cevt = '0;
    `CHK(cor_o, 32'h0000_0081)
    wr(COR, 32'h0000_0001, 4'hF);
    `CHK(cor_o, 32'h0000_0080)
  endtask

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // the whole sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    rst_in = 1'b1;
    req = '0;
    uevt = '0;
    umask = '0;
    cevt = '0;
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
    t_reset();
    t_sev_rw();
    t_msg();
    t_corr();
    t_w1c();
    stop_test();
  end
endmodule
